/* File: hdl/mbas_server.sv */
`timescale 1ns/1ps
module mbas_server
  import mbas_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request side
  input wire logic req_valid,
  output logic req_ready,
  input wire mbas_req_t req,
  // Write data words
  input wire logic wd_valid,
  output logic wd_ready,
  input wire logic [15:0] wd_data,
  // Response beats
  output logic rsp_valid,
  input wire logic rsp_ready,
  output mbas_rsp_t rsp,
  // Gateway side of the buffers
  input wire logic app_in_we,
  input wire logic [IDX_W-1:0] app_in_idx,
  input wire logic [15:0] app_in_data,
  input wire logic [IDX_W-1:0] app_out_idx,
  output logic [15:0] app_out_data,
  output logic [15:0] ctrl_word,
  output logic ctrl_cos
);

  // Range test against one area
  function automatic logic in_area(input logic [15:0] a, input logic [15:0] n,
                                   input logic [16:0] lo, input logic [16:0] hi);
    return ({1'b0, a} >= lo) && (({1'b0, a} + {1'b0, n}) <= hi);
  endfunction

  // Sixteen coils from two words, first coil in bit 0
  function automatic logic [15:0] coil_gather(input logic [15:0] w0, input logic [15:0] w1,
                                              input logic [3:0] o);
    logic [31:0] x;
    logic [15:0] g;
    x = {w0, w1} << o;
    for (int j = 0; j < 16; j++) begin
      g[j] = x[31-j];
    end
    return g;
  endfunction

  // Valid bits of a partial coil word
  function automatic logic [15:0] coil_mask(input logic [15:0] n);
    return (n >= 16'h0010) ? 16'hffff : 16'((17'h00001 << n[3:0]) - 17'h00001);
  endfunction

  logic [15:0] in_mem [BUF_WORDS];
  logic [15:0] out_mem [BUF_WORDS];
  mbas_state_t st;
  mbas_req_t r;
  logic [15:0] cur;
  logic [15:0] left;
  logic [15:0] nb;
  logic rd_out;
  logic [3:0] bitcnt;
  logic have;
  logic [15:0] wbuf;

  // Request classification
  wire logic is_coil = (r.fc == FC_RD_COIL) || (r.fc == FC_RD_DISC) ||
                       (r.fc == FC_WR_COIL) || (r.fc == FC_WR_COILS);
  wire logic has_rd = (r.fc == FC_RD_COIL) || (r.fc == FC_RD_DISC) || (r.fc == FC_RD_HOLD) ||
                      (r.fc == FC_RD_INREG) || (r.fc == FC_RW_REGS);
  wire logic single_wr = (r.fc == FC_WR_COIL) || (r.fc == FC_WR_REG) || (r.fc == FC_MASK_WR);
  wire logic multi_wr = (r.fc == FC_WR_COILS) || (r.fc == FC_WR_REGS) || (r.fc == FC_RW_REGS);
  wire logic sup = has_rd || single_wr || multi_wr;

  // Address and quantity checks
  wire logic [15:0] wr_a = (r.fc == FC_RW_REGS) ? r.waddr : r.addr;
  wire logic [15:0] wr_n = single_wr ? 16'h0001 : ((r.fc == FC_RW_REGS) ? r.wqty : r.qty);
  wire logic rd_in_ok = is_coil ? in_area(r.addr, r.qty, IN_COIL_BASE, IN_COIL_LIM)
                                : in_area(r.addr, r.qty, IN_REG_BASE, IN_REG_LIM);
  wire logic rd_out_ok = is_coil ? in_area(r.addr, r.qty, OUT_COIL_BASE, OUT_COIL_LIM)
                                 : in_area(r.addr, r.qty, OUT_REG_BASE, OUT_REG_LIM);
  wire logic wr_ok = is_coil ? in_area(wr_a, wr_n, OUT_COIL_BASE, OUT_COIL_LIM)
                             : in_area(wr_a, wr_n, OUT_REG_BASE, OUT_REG_LIM);
  logic bad_q;
  always_comb begin
    case (r.fc)
      FC_RD_COIL, FC_RD_DISC: bad_q = (r.qty == 16'h0000) || (r.qty > MAX_RD_COILS);
      FC_RD_HOLD, FC_RD_INREG: bad_q = (r.qty == 16'h0000) || (r.qty > MAX_RD_REGS);
      FC_WR_COILS: bad_q = (r.qty == 16'h0000) || (r.qty > MAX_WR_COILS);
      FC_WR_REGS: bad_q = (r.qty == 16'h0000) || (r.qty > MAX_WR_REGS);
      FC_RW_REGS: bad_q = (r.qty == 16'h0000) || (r.qty > MAX_RD_REGS) ||
                          (r.wqty == 16'h0000) || (r.wqty > MAX_RW_WR);
      default: bad_q = 1'b0;
    endcase
  end
  wire logic bad_a = (has_rd && !(rd_in_ok || rd_out_ok)) ||
                     ((single_wr || multi_wr) && !wr_ok);
  wire logic bad_v = (r.fc == FC_WR_COIL) && (r.value != COIL_ON) && (r.value != COIL_OFF);

  // Exception priority: function, quantity, address, value
  wire logic [7:0] exc = !sup ? EXC_FUNC :
                         bad_q ? EXC_VALUE :
                         bad_a ? EXC_ADDR :
                         bad_v ? EXC_VALUE : EXC_NONE;
  wire logic [15:0] rd_beats = is_coil ? 16'((17'(r.qty) + 17'h0000f) >> 4) : r.qty;
  wire logic [15:0] nbh = ((exc != EXC_NONE) || !has_rd) ? 16'h0000 : rd_beats;

  // Read path over one of the two buffers
  wire logic [15:0] rbase = !rd_out ? 16'h0000 : (is_coil ? 16'(OUT_COIL_BASE) : 16'(OUT_REG_BASE));
  wire logic [15:0] roff = cur - rbase;
  wire logic [IDX_W-1:0] ri = is_coil ? roff[11:4] : roff[7:0];
  wire logic [IDX_W-1:0] ri1 = ri + 8'h01;
  wire logic [15:0] w0 = rd_out ? out_mem[ri] : in_mem[ri];
  wire logic [15:0] w1 = rd_out ? out_mem[ri1] : in_mem[ri1];
  wire logic [15:0] rword = is_coil ? (coil_gather(w0, w1, roff[3:0]) & coil_mask(left)) : w0;

  // Write path into the output buffer, coils read-modify-write the shared word
  wire logic [15:0] wa = (st == S_EVAL) ? wr_a : cur;
  wire logic [15:0] woff = wa - (is_coil ? 16'(OUT_COIL_BASE) : 16'(OUT_REG_BASE));
  wire logic [IDX_W-1:0] widx = is_coil ? woff[11:4] : woff[7:0];
  wire logic [15:0] wold = out_mem[widx];
  wire logic wbit = (st == S_EVAL) ? (r.value == COIL_ON) : wbuf[bitcnt];
  wire logic [15:0] bm = 16'h8000 >> woff[3:0];
  wire logic [15:0] wcoil = wbit ? (wold | bm) : (wold & ~bm);
  logic [15:0] wval;
  always_comb begin
    case (r.fc)
      FC_WR_COIL, FC_WR_COILS: wval = wcoil;
      FC_WR_REG: wval = r.value;
      FC_MASK_WR: wval = (wold & r.value) | (r.or_mask & ~r.value);
      default: wval = wd_data;
    endcase
  end

  // Strobes of the sequencer
  wire logic we = ((st == S_EVAL) && (exc == EXC_NONE) && single_wr) ||
                  ((st == S_WR) && (is_coil ? have : wd_valid));
  wire logic wr_last = (st == S_WR) && we && (left == 16'h0001);
  wire logic ld_hdr = ((st == S_EVAL) && ((exc != EXC_NONE) || !multi_wr)) || wr_last;
  wire logic ld_data = (st == S_RD) && (nb != 16'h0000) && (!rsp_valid || rsp_ready);
  assign req_ready = (st == S_IDLE) && !rsp_valid;
  assign wd_ready = (st == S_WR) && (!is_coil || !have);

  // Header beat
  mbas_rsp_t hdr;
  always_comb begin
    hdr.conn = r.conn;
    hdr.fc = (exc != EXC_NONE) ? (r.fc | EXC_FLAG) : r.fc;
    hdr.code = exc;
    hdr.last = (nbh == 16'h0000);
    hdr.data = nbh;
  end

  // Request sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= S_IDLE;
      r <= '0;
      cur <= 16'h0000;
      left <= 16'h0000;
      nb <= 16'h0000;
      rd_out <= 1'b0;
      bitcnt <= 4'h0;
      have <= 1'b0;
      wbuf <= 16'h0000;
    end else begin
      case (st)
        S_IDLE: begin
          if (req_valid && req_ready) begin
            r <= req;
            if (req.port == TCP_PORT) begin
              st <= S_EVAL;
            end
          end
        end
        S_EVAL: begin
          rd_out <= !rd_in_ok;
          cur <= multi_wr ? wr_a : r.addr;
          left <= multi_wr ? wr_n : r.qty;
          nb <= nbh;
          bitcnt <= 4'h0;
          have <= 1'b0;
          st <= (multi_wr && (exc == EXC_NONE)) ? S_WR : S_RD;
        end
        S_WR: begin
          if (wd_valid && wd_ready && is_coil) begin
            wbuf <= wd_data;
            have <= 1'b1;
          end
          if (we) begin
            cur <= cur + 16'h0001;
            left <= left - 16'h0001;
            if (is_coil) begin
              bitcnt <= bitcnt + 4'h1;
              if ((bitcnt == 4'hf) || (left == 16'h0001)) begin
                have <= 1'b0;
                bitcnt <= 4'h0;
              end
            end
          end
          if (wr_last) begin
            cur <= r.addr;
            left <= r.qty;
            nb <= nbh;
            st <= S_RD;
          end
        end
        S_RD: begin
          if (ld_data) begin
            cur <= cur + (is_coil ? 16'h0010 : 16'h0001);
            left <= left - (is_coil ? 16'h0010 : 16'h0001);
            nb <= nb - 16'h0001;
          end
          if (nb == 16'h0000) begin
            st <= S_IDLE;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // Response register
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else if (ld_hdr) begin
      rsp_valid <= 1'b1;
      rsp <= hdr;
    end else if (ld_data) begin
      rsp_valid <= 1'b1;
      rsp <= '{conn: r.conn, fc: r.fc, code: EXC_NONE, last: (nb == 16'h0001), data: rword};
    end else if (rsp_ready) begin
      rsp_valid <= 1'b0;
    end
  end

  // Output buffer storage and gateway read port
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        out_mem[i] <= 16'h0000;
      end
      app_out_data <= 16'h0000;
    end else begin
      if (we) begin
        out_mem[widx] <= wval;
      end
      app_out_data <= out_mem[app_out_idx];
    end
  end

  // Input buffer, filled by the gateway side only; word 0 is the status word
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        in_mem[i] <= 16'h0000;
      end
    end else if (app_in_we) begin
      in_mem[app_in_idx] <= app_in_data;
    end
  end

  // Control word copy and change strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_word <= 16'h0000;
      ctrl_cos <= 1'b0;
    end else begin
      ctrl_cos <= 1'b0;
      if (we && (widx == 8'h00)) begin
        ctrl_word <= wval;
        ctrl_cos <= (wval != ctrl_word);
      end
    end
  end

  // Checks
  property p_port_drop;
    @(posedge clk) disable iff (rst)
      (req_valid && req_ready && (req.port != TCP_PORT)) |=> (st == S_IDLE) && !rsp_valid;
  endproperty
  a_port_drop: assert property (p_port_drop) else $error("foreign port served");

  property p_conn_echo;
    @(posedge clk) disable iff (rst)
      rsp_valid |-> (rsp.conn == r.conn);
  endproperty
  a_conn_echo: assert property (p_conn_echo) else $error("slot not echoed");

  property p_exc_func;
    @(posedge clk) disable iff (rst)
      ((st == S_EVAL) && !sup) |=> rsp_valid && (rsp.code == 8'h01) && rsp.fc[7] && rsp.last;
  endproperty
  a_exc_func: assert property (p_exc_func) else $error("no exception 01h");

  property p_exc_addr;
    @(posedge clk) disable iff (rst)
      ((st == S_EVAL) && sup && !bad_q && bad_a) |=> rsp_valid && (rsp.code == 8'h02);
  endproperty
  a_exc_addr: assert property (p_exc_addr) else $error("no exception 02h");

  property p_exc_value;
    @(posedge clk) disable iff (rst)
      ((st == S_EVAL) && sup && (bad_q || (!bad_a && bad_v))) |=> (rsp.code == 8'h03);
  endproperty
  a_exc_value: assert property (p_exc_value) else $error("no exception 03h");

  property p_no_write_on_exc;
    @(posedge clk) disable iff (rst)
      ((st == S_EVAL) && (exc != EXC_NONE)) |-> !we ##1 (st == S_RD) ##1 !we;
  endproperty
  a_no_write_on_exc: assert property (p_no_write_on_exc) else $error("write despite exception");

  property p_ctrl_copy;
    @(posedge clk) disable iff (rst)
      (we && (widx == 8'h00)) |=> (ctrl_word == $past(wval)) && (out_mem[0] == ctrl_word);
  endproperty
  a_ctrl_copy: assert property (p_ctrl_copy) else $error("control word not updated");

  property p_reg_read;
    @(posedge clk) disable iff (rst)
      (ld_data && !is_coil) |=> (rsp.data == $past(w0)) && rsp_valid;
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("register word mismatch");
endmodule

/* File: hdl/mbas_pkg.sv */
package mbas_pkg;
  // Connection slots and service port
  localparam int CONN_MAX = 8;
  localparam int CONN_W = $clog2(CONN_MAX);
  localparam logic [15:0] TCP_PORT = 16'h01f6;

  // Buffer geometry
  localparam int BUF_WORDS = 256;
  localparam int IDX_W = 8;

  // Register numbers of status and control word
  localparam logic [15:0] REG_STATUS = 16'h0001;
  localparam logic [15:0] REG_CONTROL = 16'h0401;

  // Zero based request address areas, upper bounds exclusive
  localparam logic [16:0] IN_REG_BASE = 17'h00000;
  localparam logic [16:0] IN_REG_LIM = 17'h00100;
  localparam logic [16:0] OUT_REG_BASE = 17'h00400;
  localparam logic [16:0] OUT_REG_LIM = 17'h00500;
  localparam logic [16:0] IN_COIL_BASE = 17'h00000;
  localparam logic [16:0] IN_COIL_LIM = 17'h01000;
  localparam logic [16:0] OUT_COIL_BASE = 17'h04000;
  localparam logic [16:0] OUT_COIL_LIM = 17'h05000;

  // Function codes
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DISC = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] FC_MASK_WR = 8'h16;
  localparam logic [7:0] FC_RW_REGS = 8'h17;

  // Exception codes and flag
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_FLAG = 8'h80;

  // Quantity limits and single coil values
  localparam logic [15:0] MAX_RD_COILS = 16'h07d0;
  localparam logic [15:0] MAX_RD_REGS = 16'h007d;
  localparam logic [15:0] MAX_WR_COILS = 16'h07b0;
  localparam logic [15:0] MAX_WR_REGS = 16'h007b;
  localparam logic [15:0] MAX_RW_WR = 16'h0079;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;

  // Parsed request from the transport side
  typedef struct packed {
    logic [CONN_W-1:0] conn;
    logic [15:0] port;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] waddr;
    logic [15:0] wqty;
    logic [15:0] value;
    logic [15:0] or_mask;
  } mbas_req_t;

  // One response beat
  typedef struct packed {
    logic [CONN_W-1:0] conn;
    logic [7:0] fc;
    logic [7:0] code;
    logic last;
    logic [15:0] data;
  } mbas_rsp_t;

  typedef enum logic [1:0] {S_IDLE, S_EVAL, S_WR, S_RD} mbas_state_t;
endpackage

/* File: tb/mbas_master_model.sv */
`timescale 1ns/1ps
// Network master stand-in: consumes response beats, promptly or with stalls
module mbas_master_model
  import mbas_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Response sink
  input wire logic rsp_valid,
  output logic rsp_ready,
  // Pace and service port
  input wire logic slow,
  output logic [15:0] port
);
  // Master always targets the service port
  assign port = TCP_PORT;
  // Accept every beat, or stall at random when slow
  always @(negedge clk) begin
    rsp_ready <= rst ? 1'b0 : (!slow || ($urandom % 3 == 0));
  end
endmodule

/* File: tb/modbus_buffer_access_server_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the request server
module modbus_buffer_access_server_test;
  import mbas_pkg::*;
  // Refused requests: fc, addr, qty, value, exception
  localparam logic [63:0] XT [12] = '{64'h07_0000_0001_0000_01, 64'h08_0000_0001_0000_01,
    64'h03_0100_0001_0000_02, 64'h03_00ff_0002_0000_02, 64'h02_5000_0001_0000_02,
    64'h04_0500_0001_0000_02, 64'h06_0001_0000_5a5a_02, 64'h05_0000_0000_ff00_02,
    64'h03_0000_0000_0000_03, 64'h03_0000_007e_0000_03, 64'h01_0000_07d1_0000_03,
    64'h05_4000_0000_1234_03};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready;
  mbas_req_t req = '0;
  logic wd_valid = 1'b0;
  logic wd_ready;
  logic [15:0] wd_data = 16'h0000;
  logic rsp_valid;
  logic rsp_ready;
  mbas_rsp_t rsp;
  logic app_in_we = 1'b0;
  logic [7:0] app_in_idx = 8'h00;
  logic [15:0] app_in_data = 16'h0000;
  logic [7:0] app_out_idx = 8'h00;
  logic [15:0] app_out_data;
  logic [15:0] ctrl_word;
  logic ctrl_cos;
  logic slow = 1'b0;
  logic [15:0] mport;
  logic [15:0] in_m [256];
  logic [15:0] out_m [256];
  mbas_rsp_t eq [$];
  mbas_req_t r;
  logic [15:0] w0;
  logic [15:0] w1;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_cos = 0;

  // Unit under test and the far side
  mbas_server DUT (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp(rsp), .app_in_we(app_in_we), .app_in_idx(app_in_idx),
    .app_in_data(app_in_data), .app_out_idx(app_out_idx), .app_out_data(app_out_data),
    .ctrl_word(ctrl_word), .ctrl_cos(ctrl_cos));
  mbas_master_model partner (.clk(clk), .rst(rst), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .slow(slow), .port(mport));

  // Clock
  always #25 clk = ~clk;

  task automatic end_of_test();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Data is ignored on exception beats
  task automatic chk_rsp(input mbas_rsp_t e, input mbas_rsp_t g);
    n_tests++;
    if (g.conn !== e.conn || g.fc !== e.fc || g.code !== e.code || g.last !== e.last ||
        (e.code === EXC_NONE && g.data !== e.data)) begin
      mismatches++;
      $display("CHECK FAILED rsp expected %h seen %h", e, g);
    end
  endtask

  // Register word and coil bit from the bench's buffer copies
  function automatic logic [15:0] wrd(input logic [15:0] a);
    wrd = (a < 16'h0400) ? in_m[a[7:0]] : out_m[a[7:0]];
  endfunction

  function automatic logic cbit(input logic [15:0] a);
    logic [15:0] w;
    w = (a < 16'h4000) ? in_m[a[11:4]] : out_m[a[11:4]];
    cbit = w[4'hf - a[3:0]];
  endfunction

  task automatic note(input logic [7:0] code, input logic lst, input logic [15:0] d);
    eq.push_back('{conn: r.conn, fc: (code === EXC_NONE) ? r.fc : (r.fc | EXC_FLAG), code: code,
      last: lst, data: d});
  endtask

  task automatic set(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] n);
    r = '0;
    r.conn = CONN_W'($urandom);
    r.port = mport;
    r.fc = fc;
    r.addr = a;
    r.qty = n;
  endtask

  // Offer a request and hold it until taken
  task automatic go();
    @(negedge clk);
    req = r;
    req_valid = 1'b1;
    // Ready is registered state, settled at the falling edge
    while (!req_ready) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic wr(input logic [15:0] d);
    @(negedge clk);
    wd_data = d;
    wd_valid = 1'b1;
    while (!wd_ready) @(negedge clk);
    @(posedge clk);
  endtask

  task automatic wd_end();
    @(negedge clk);
    wd_valid = 1'b0;
  endtask

  task automatic idle();
    @(negedge clk);
    while (!req_ready || eq.size() != 0) @(negedge clk);
  endtask

  task automatic app_wr(input logic [7:0] i, input logic [15:0] d);
    @(negedge clk);
    app_in_we = 1'b1;
    app_in_idx = i;
    app_in_data = d;
    in_m[i] = d;
    @(negedge clk);
    app_in_we = 1'b0;
  endtask

  task automatic chk_out(input logic [7:0] i, input logic [15:0] e);
    @(negedge clk);
    app_out_idx = i;
    @(negedge clk);
    chk16("app_out_data", e, app_out_data);
  endtask

  task automatic wsingle(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] v);
    set(fc, a, 16'h0000);
    r.value = v;
    note(EXC_NONE, 1'b1, 16'h0000);
    go();
  endtask

  // Coil reads pack coil addr+16k+j into bit j
  task automatic rd(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] n);
    logic [15:0] d;
    int beats;
    set(fc, a, n);
    beats = (fc < FC_RD_HOLD) ? (n + 15) / 16 : n;
    note(EXC_NONE, beats == 0, 16'(beats));
    for (int k = 0; k < beats; k++) begin
      if (fc < FC_RD_HOLD) begin
        for (int j = 0; j < 16; j++) d[j] = (16 * k + j < n) ? cbit(a + 16'(16 * k + j)) : 1'b0;
      end
      else d = wrd(a + 16'(k));
      note(EXC_NONE, k == beats - 1, d);
    end
    go();
  endtask

  // Response watcher takes the oldest note per accepted beat
  always @(posedge clk) begin
    if (!rst && rsp_valid && rsp_ready) begin
      if (eq.size() == 0) begin
        mismatches++;
        $display("CHECK FAILED rsp expected none seen %h", rsp);
      end
      else chk_rsp(eq.pop_front(), rsp);
    end
  end

  // Control word change strobes
  always @(posedge clk) begin
    if (!rst && ctrl_cos === 1'b1) n_cos++;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(23));
    foreach (in_m[i]) in_m[i] = 16'h0000;
    foreach (out_m[i]) out_m[i] = 16'h0000;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk16("ctrl_word", 16'h0000, ctrl_word);
    for (int i = 0; i < 3; i++) app_wr(8'(i), 16'($urandom));
    app_wr(8'hff, 16'($urandom));
    for (int f = 1; f <= 4; f++) rd(8'(f), 16'h0000, (f < 3) ? 16'd20 : 16'd3);
    rd(FC_RD_HOLD, 16'h00ff, 16'h0001);
    set(FC_RD_HOLD, 16'h0000, 16'h0001);
    r.port = 16'h01f7;
    go();
    // Bit 15 set and bit 12 clear, so both coil writes below change word 0
    w0 = (16'($urandom) | 16'h8000) & 16'hefff;
    w1 = 16'($urandom);
    set(FC_WR_REGS, 16'h0400, 16'h0002);
    note(EXC_NONE, 1'b1, 16'h0000);
    go();
    wr(w0);
    wr(w1);
    wd_end();
    out_m[0] = w0;
    out_m[1] = w1;
    idle();
    chk16("ctrl_word", w0, ctrl_word);
    chk_out(8'h01, w1);
    slow = 1'b1;
    wsingle(FC_WR_COIL, 16'h4003, COIL_ON);
    out_m[0][12] = 1'b1;
    wsingle(FC_WR_COIL, 16'h4000, COIL_OFF);
    out_m[0][15] = 1'b0;
    wsingle(FC_WR_REG, 16'h04ff, w1);
    out_m[255] = w1;
    rd(FC_RD_COIL, 16'h4000, 16'd32);
    rd(FC_RD_INREG, 16'h0400, 16'h0002);
    rd(FC_RD_HOLD, 16'h04ff, 16'h0001);
    // Twenty coils across words 1 and 2, coil n+16k+j in bit j of data word k
    set(FC_WR_COILS, 16'h4010, 16'd20);
    note(EXC_NONE, 1'b1, 16'h0000);
    go();
    wr(w1);
    wr(w0);
    wd_end();
    for (int j = 0; j < 20; j++) out_m[1 + j / 16][15 - j % 16] = (j < 16) ? w1[j] : w0[j - 16];
    idle();
    chk_out(8'h01, out_m[1]);
    chk_out(8'h02, out_m[2]);
    set(FC_MASK_WR, 16'h0401, 16'h0000);
    r.value = 16'hf0f0;
    r.or_mask = 16'h5aa5;
    note(EXC_NONE, 1'b1, 16'h0000);
    go();
    out_m[1] = (out_m[1] & 16'hf0f0) | 16'h0a05;
    idle();
    chk_out(8'h01, out_m[1]);
    out_m[2] = w0;
    set(FC_RW_REGS, 16'h0401, 16'h0002);
    r.waddr = 16'h0402;
    r.wqty = 16'h0001;
    note(EXC_NONE, 1'b0, 16'h0002);
    note(EXC_NONE, 1'b0, out_m[1]);
    note(EXC_NONE, 1'b1, out_m[2]);
    go();
    wr(w0);
    wd_end();
    foreach (XT[i]) begin
      set(XT[i][63:56], XT[i][55:40], XT[i][39:24]);
      r.value = XT[i][23:8];
      note(XT[i][7:0], 1'b1, 16'h0000);
      go();
    end
    rd(FC_RD_HOLD, 16'h0000, 16'h0003);
    idle();
    chk16("pending", 16'h0000, 16'(eq.size()));
    chk16("ctrl_cos", 16'h0003, 16'(n_cos));
    end_of_test();
  end
endmodule
